// [rtl/acqh_defines.svh]
`ifndef ACQH_DEFINES_SVH
`define ACQH_DEFINES_SVH
// Command identifiers
`define ACQH_CMD_PING 16'h0001
`define ACQH_CMD_CONFIG 16'h0002
`define ACQH_CMD_WR_MODE 16'h0003
`define ACQH_CMD_RD_MODE 16'h0004
`define ACQH_CMD_WR_SET 16'h0005
`define ACQH_CMD_RD_SET 16'h0006
`define ACQH_CMD_WR_ACT 16'h0007
`define ACQH_CMD_RD_ACT 16'h0008
`define ACQH_CMD_WR_MASK 16'h0009
`define ACQH_CMD_RD_MASK 16'h000A
// Reply codes and flag positions
`define ACQH_REPLY_BIT 15
`define ACQH_ASYNC_BIT 12
`define ACQH_BCAST_BIT 15
`define ACQH_ERR_UNKNOWN 16'h7F04
`define ACQH_ID_BUSY 16'h0000
// Field layout
`define ACQH_NIB_HI 3
`define ACQH_SGL_TICK_HI 3
`define ACQH_SGL_TICK_LO 0
// Scope settings fields
`define ACQH_TOT_HI 12
`define ACQH_TOT_LO 4
`define ACQH_PRE_HI 19
`define ACQH_PRE_LO 16
`define ACQH_WIN_HI 27
`define ACQH_WIN_LO 24
// Reset values
`define ACQH_MODE_RST 4'h0
`define ACQH_SET_RST 32'h0000_0000
`define ACQH_ACT_RST 4'h0
`define ACQH_MASK_RST 32'h0000_0000
`define ACQH_ADDR_RST 16'h0000
// Build-time pipeline depth: ceil(ticks / slice_period) + 1
`define ACQH_EVT_TICKS 15
`define ACQH_SLICE_PERIOD 8
`define ACQH_PIPE_DEPTH ((`ACQH_EVT_TICKS + `ACQH_SLICE_PERIOD - 1) / `ACQH_SLICE_PERIOD + 1)
// Child load: words streamed from flash per load
`define ACQH_CFG_WORDS 16'h0010
`define ACQH_CFG_LAST 16'h000F
`endif

// [rtl/acqh_pkg.sv]
package acqh_pkg;
    // Acquisition modes
    typedef enum logic [3:0] {
        ACQH_MODE_IDLE = 4'h0,
        ACQH_MODE_SCOPE = 4'h1,
        ACQH_MODE_SINGLES = 4'h2
    } acqh_mode_t;
    // Acquisition actions
    typedef enum logic [3:0] {
        ACQH_ACT_RESET = 4'h0,
        ACQH_ACT_STOP = 4'h1,
        ACQH_ACT_RUN = 4'h2
    } acqh_action_t;
    // Command handler states
    typedef enum logic [1:0] {
        ACQH_ST_IDLE,
        ACQH_ST_EXEC,
        ACQH_ST_CONFIG,
        ACQH_ST_REPLY
    } acqh_state_t;
endpackage

// [rtl/acqh_cfg_if.sv]
`timescale 1ns/10ps
// Handshake between the handler and the child loader
interface acqh_cfg_if;
    logic start; // Pulse: begin a load
    logic busy; // Level: load in progress
    modport ctrl (output start, input busy);
    modport load (input start, output busy);
endinterface

// [rtl/acqh_child_loader.sv]
`timescale 1ns/10ps
`include "acqh_defines.svh"
// Streams the child bitstream from flash into the child devices
module acqh_child_loader (
    input wire logic clk,
    input wire logic resetn,
    acqh_cfg_if.load cfg,
    output logic flash_rd_r,
    input wire logic [31:0] flash_data,
    output logic [31:0] child_data_r,
    output logic child_we_r
);
    logic [15:0] word_cnt_r; // Words left to move after the current one
    logic active_r; // Load running

    // Word sequencer; a start while a load is active is ignored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_r <= 1'b0;
            word_cnt_r <= 16'h0000;
        end else if (!active_r && cfg.start) begin
            active_r <= 1'b1;
            word_cnt_r <= `ACQH_CFG_LAST;
        end else if (active_r) begin
            if (word_cnt_r == 16'h0000) begin
                active_r <= 1'b0;
            end else begin
                word_cnt_r <= word_cnt_r - 16'h0001;
            end
        end
    end

    // Flash read strobe one cycle ahead of the child write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flash_rd_r <= 1'b0;
            child_we_r <= 1'b0;
            child_data_r <= 32'h0000_0000;
        end else begin
            flash_rd_r <= active_r;
            child_we_r <= flash_rd_r;
            child_data_r <= flash_data;
        end
    end

    // Busy covers the tail of the write pipe too
    assign cfg.busy = active_r | flash_rd_r | child_we_r;
endmodule // acqh_child_loader

// [rtl/acqh_cmd_handler.sv]
`timescale 1ns/10ps
`include "acqh_defines.svh"
// How it works
// - Ping replies only, payload ignored
// - Reply id has top bit set, except the unknown-command error code
// - Broadcast runs everywhere, only target replies
// - Async command gets immediate reply
// - Async target busy until execution done
// - Configure loads child bitstream, also at power-up
// - Write mode keeps low four bits
// - Mode 0 idle, 1 scope, 2 singles
// - Read mode returns stored mode
// - Write settings stores 32-bit word
// - Scope settings field layout
// - Singles settings hold event tick count
// - Pipeline depth is a build constant
// - Read settings returns stored word
// - Write action stores low four bits
// - Reset action clears mode, stop ends run
// - Mask gates channel triggers
// - Read action and mask return stored values
// - Unknown command replies with error code
// - No reply ready shows busy id
module acqh_cmd_handler (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] node_addr, // This node's address
    input wire logic cmd_valid, // Command strobe from parent
    input wire logic [15:0] cmd_id,
    input wire logic [15:0] cmd_dest, // destination_field
    input wire logic [31:0] cmd_payload,
    output logic cmd_busy_r, // High while a command is in hand
    output logic rsp_valid_r, // One-cycle reply strobe
    output logic [15:0] rsp_id_r,
    output logic [15:0] rsp_src_r,
    output logic [31:0] rsp_payload_r,
    output logic [3:0] acq_mode_r, // acquisition_mode low nibble
    output logic [31:0] acq_settings_r, // acquisition_settings
    output logic [3:0] acq_action_r, // acquisition_action low nibble
    output logic [31:0] trig_mask_r, // channel_trigger_mask
    output logic acq_running_r, // Acquisition in progress
    output logic scope_en_r, // Oscilloscope capture enabled
    output logic singles_en_r, // Event processing enabled
    output logic [8:0] scope_total_r,
    output logic [3:0] scope_pretrig_r,
    output logic [3:0] scope_window_r,
    output logic [3:0] singles_ticks_r,
    input wire logic [31:0] chan_trig, // Raw channel triggers
    output logic [31:0] chan_trig_ok_r, // Triggers after mask
    output logic flash_rd_r,
    input wire logic [31:0] flash_data,
    output logic [31:0] child_data_r,
    output logic child_we_r
);
    // Fixed singles pipeline depth, local to this module; no port carries it
    localparam int PIPE_DEPTH = `ACQH_PIPE_DEPTH;

    acqh_pkg::acqh_state_t state_r; // Handler state
    logic [15:0] id_r; // Latched command id
    logic [31:0] pay_r; // Latched payload
    logic async_r; // Latched async flag
    logic for_me_r; // This node is the reply source
    logic pwrup_r; // Power-up load still pending
    logic pwrup_kick_r; // Power-up load not yet launched
    logic [31:0] rd_data_r; // Reply payload staged
    logic [15:0] rd_id_r; // Reply id staged

    // Loader handshake, private to this module
    acqh_cfg_if cfg_bus ();

    // Reply id: echo with top bit forced
    // Async flag is kept, so both forms stay distinct
    function automatic logic [15:0] echo_id(input logic [15:0] id);
        echo_id = id | (16'h0001 << `ACQH_REPLY_BIT);
    endfunction

    // Known command test; strips the async flag first
    // A range test holds while the ids stay contiguous
    function automatic logic known_cmd(input logic [15:0] id);
        logic [15:0] base;
        base = id & ~(16'h0001 << `ACQH_ASYNC_BIT);
        known_cmd = (base >= `ACQH_CMD_PING) && (base <= `ACQH_CMD_RD_MASK);
    endfunction

    // Mode decode; undefined codes fall back to idle
    // so a stray code cannot enable either engine
    function automatic acqh_pkg::acqh_mode_t mode_of(input logic [3:0] m);
        unique case (m)
            4'h1: begin
                mode_of = acqh_pkg::ACQH_MODE_SCOPE;
            end
            4'h2: begin
                mode_of = acqh_pkg::ACQH_MODE_SINGLES;
            end
            default: begin
                mode_of = acqh_pkg::ACQH_MODE_IDLE;
            end
        endcase
    endfunction

    // Shared by the sequencer, writes and reply mux
    logic [15:0] base_id; // Id with async flag cleared
    assign base_id = id_r & ~(16'h0001 << `ACQH_ASYNC_BIT);

    // Serves both the power-up load and configure
    acqh_child_loader u_loader (
        .clk(clk),
        .resetn(resetn),
        .cfg(cfg_bus.load),
        .flash_rd_r(flash_rd_r),
        .flash_data(flash_data),
        .child_data_r(child_data_r),
        .child_we_r(child_we_r)
    );

    // Command sequencer; commands arriving while busy are dropped
    // One command in hand at a time, so no queue
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= acqh_pkg::ACQH_ST_IDLE;
            id_r <= `ACQH_ID_BUSY;
            pay_r <= 32'h0000_0000;
            async_r <= 1'b0;
            for_me_r <= 1'b0;
        end else begin
            unique case (state_r)
                acqh_pkg::ACQH_ST_IDLE: begin
                    if (cmd_valid && !pwrup_r) begin
                        id_r <= cmd_id;
                        pay_r <= cmd_payload;
                        async_r <= cmd_id[`ACQH_ASYNC_BIT];
                        // Broadcast executes here too; reply only if addressed
                        for_me_r <= ((cmd_dest & ~(16'h0001 << `ACQH_BCAST_BIT))
                                     == node_addr);
                        state_r <= acqh_pkg::ACQH_ST_EXEC;
                    end
                end

                acqh_pkg::ACQH_ST_EXEC: begin
                    // Configure waits for loader; others finish in one cycle
                    if (base_id == `ACQH_CMD_CONFIG) begin
                        state_r <= acqh_pkg::ACQH_ST_CONFIG;
                    end else begin
                        state_r <= acqh_pkg::ACQH_ST_REPLY;
                    end
                end

                acqh_pkg::ACQH_ST_CONFIG: begin
                    // A synchronous target stays silent until the load completes; an async one replied in EXEC
                    if (!cfg_bus.busy) begin
                        state_r <= acqh_pkg::ACQH_ST_REPLY;
                    end
                end

                acqh_pkg::ACQH_ST_REPLY: begin
                    state_r <= acqh_pkg::ACQH_ST_IDLE;
                end
            endcase
        end
    end

    // Power-up load runs once after reset, before any command.
    // The kick lasts one cycle: the idle loader takes it at once,
    // and a kick still high after the load ends would start a second one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwrup_r <= 1'b1;
            pwrup_kick_r <= 1'b1;
        end else begin
            pwrup_kick_r <= 1'b0;
            // Pending drops once the loader ran and went idle
            if (pwrup_r && !pwrup_kick_r && !cfg_bus.busy) begin
                pwrup_r <= 1'b0;
            end
        end
    end

    // Load kick: power-up or configure command
    // Start is a one-cycle pulse the loader samples only when idle
    always_comb begin
        cfg_bus.start = 1'b0;
        if (pwrup_kick_r) begin
            cfg_bus.start = 1'b1;
        end else if (state_r == acqh_pkg::ACQH_ST_EXEC && base_id == `ACQH_CMD_CONFIG) begin
            cfg_bus.start = 1'b1;
        end
    end

    // Register writes, done in the execute cycle
    // Broadcast writes land here, reply or not
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acq_mode_r <= `ACQH_MODE_RST;
            acq_settings_r <= `ACQH_SET_RST;
            acq_action_r <= `ACQH_ACT_RST;
            trig_mask_r <= `ACQH_MASK_RST;
        end else if (state_r == acqh_pkg::ACQH_ST_EXEC) begin
            unique case (base_id)
                `ACQH_CMD_WR_MODE: begin
                    acq_mode_r <= pay_r[`ACQH_NIB_HI:0];
                end
                `ACQH_CMD_WR_SET: begin
                    acq_settings_r <= pay_r;
                end
                `ACQH_CMD_WR_ACT: begin
                    acq_action_r <= pay_r[`ACQH_NIB_HI:0];
                    // Reset action returns mode and settings to defaults
                    if (pay_r[`ACQH_NIB_HI:0] == acqh_pkg::ACQH_ACT_RESET) begin
                        acq_mode_r <= `ACQH_MODE_RST;
                        acq_settings_r <= `ACQH_SET_RST;
                    end
                end
                `ACQH_CMD_WR_MASK: begin
                    trig_mask_r <= pay_r;
                end
                default: begin
                    // Reads, ping and configure store nothing
                end
            endcase
        end
    end

    // Reply staging; reads ignore the request payload
    // Plain mux; the reply port registers its result
    always_comb begin
        rd_data_r = 32'h0000_0000;
        rd_id_r = echo_id(id_r);
        if (!known_cmd(id_r)) begin
            rd_id_r = `ACQH_ERR_UNKNOWN;
        end else begin
            unique case (base_id)
                `ACQH_CMD_RD_MODE: begin
                    rd_data_r = {28'h0, acq_mode_r};
                end
                `ACQH_CMD_RD_SET: begin
                    rd_data_r = acq_settings_r;
                end
                `ACQH_CMD_RD_ACT: begin
                    rd_data_r = {28'h0, acq_action_r};
                end
                `ACQH_CMD_RD_MASK: begin
                    rd_data_r = trig_mask_r;
                end
                // Writes echo their payload; ping returns zero
                `ACQH_CMD_WR_MODE, `ACQH_CMD_WR_SET, `ACQH_CMD_WR_ACT,
                `ACQH_CMD_WR_MASK: rd_data_r = pay_r;
                default: rd_data_r = 32'h0000_0000;
            endcase
        end
    end

    // Reply port; busy id shown whenever nothing is ready
    // One reply per command: async in EXEC, rest in REPLY
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_r <= 1'b0;
            rsp_id_r <= `ACQH_ID_BUSY;
            rsp_src_r <= `ACQH_ADDR_RST;
            rsp_payload_r <= 32'h0000_0000;
        end else begin
            rsp_valid_r <= 1'b0;
            rsp_id_r <= `ACQH_ID_BUSY;
            rsp_payload_r <= 32'h0000_0000;
            if (state_r == acqh_pkg::ACQH_ST_EXEC && async_r && for_me_r) begin
                // Async: acknowledge at once, before execution ends
                rsp_valid_r <= 1'b1;
                rsp_id_r <= rd_id_r;
                rsp_src_r <= node_addr;
                rsp_payload_r <= rd_data_r;
            end else if (state_r == acqh_pkg::ACQH_ST_REPLY && !async_r && for_me_r) begin
                rsp_valid_r <= 1'b1;
                rsp_id_r <= rd_id_r;
                rsp_src_r <= node_addr;
                rsp_payload_r <= rd_data_r;
            end
        end
    end

    // Busy flag for the parent
    // Counting cmd_valid covers the first EXEC cycle, before the state shows in the flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_busy_r <= 1'b1;
        end else begin
            cmd_busy_r <= pwrup_r || (state_r != acqh_pkg::ACQH_ST_IDLE) || cmd_valid;
        end
    end

    // Acquisition control: run starts, stop or reset ends
    // Action is a level, so run holds until changed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acq_running_r <= 1'b0;
            scope_en_r <= 1'b0;
            singles_en_r <= 1'b0;
        end else begin
            unique case (acq_action_r)
                4'h2: begin
                    acq_running_r <= 1'b1;
                end
                4'h0, 4'h1: begin
                    acq_running_r <= 1'b0;
                end
                default: begin
                    // Undefined action: leave state alone
                end
            endcase

            // Mode decode gates the engines
            scope_en_r <= acq_running_r && (mode_of(acq_mode_r) == acqh_pkg::ACQH_MODE_SCOPE);
            singles_en_r <= acq_running_r
                            && (mode_of(acq_mode_r) == acqh_pkg::ACQH_MODE_SINGLES);
        end
    end

    // Settings fields split by mode
    // Every field is split; the mode gates its use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scope_total_r <= 9'h000;
            scope_pretrig_r <= 4'h0;
            scope_window_r <= 4'h0;
            singles_ticks_r <= 4'h0;
        end else begin
            scope_total_r <= acq_settings_r[`ACQH_TOT_HI:`ACQH_TOT_LO];
            scope_pretrig_r <= acq_settings_r[`ACQH_PRE_HI:`ACQH_PRE_LO];
            scope_window_r <= acq_settings_r[`ACQH_WIN_HI:`ACQH_WIN_LO];
            singles_ticks_r <= acq_settings_r[`ACQH_SGL_TICK_HI:`ACQH_SGL_TICK_LO];
        end
    end

    // Trigger gating: a zero bit suppresses that channel
    // One cycle of latency, alike for all channels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_trig_ok_r <= 32'h0000_0000;
        end else begin
            chan_trig_ok_r <= chan_trig & trig_mask_r;
        end
    end
endmodule // acqh_cmd_handler

// [dv/acqh_cmd_handler_monitor.sv]
`timescale 1ns/10ps
// Watches the command and reply ports of the handler
module acqh_cmd_handler_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] node_addr,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_id,
    input wire logic [15:0] cmd_dest,
    input wire logic [31:0] cmd_payload,
    input wire logic cmd_busy_r,
    input wire logic rsp_valid_r,
    input wire logic [15:0] rsp_id_r,
    input wire logic [15:0] rsp_src_r,
    input wire logic [31:0] rsp_payload_r,
    input wire logic [3:0] acq_mode_r,
    input wire logic [31:0] acq_settings_r,
    input wire logic [31:0] trig_mask_r,
    input wire logic [31:0] chan_trig,
    input wire logic [31:0] chan_trig_ok_r
);
    // Accepted command, and whether it names this node once broadcast is stripped
    wire take = cmd_valid && !cmd_busy_r;
    wire hit = {1'b0, cmd_dest[14:0]} == node_addr;
    wire [15:0] base_id = cmd_id & 16'hEFFF;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    reply_mark_a: assert property (rsp_valid_r && rsp_id_r != 16'h7F04 |-> rsp_id_r[15])
        else $error("reply id lacks top bit");
    reply_src_a: assert property (rsp_valid_r |-> rsp_src_r == node_addr)
        else $error("reply source is not this node");
    idle_busy_id_a: assert property (!rsp_valid_r |-> rsp_id_r == 16'h0000)
        else $error("idle reply id not zero");
    mask_gate_a: assert property (chan_trig_ok_r == ($past(chan_trig) & $past(trig_mask_r)))
        else $error("trigger not gated by mask");
    ping_reply_a: assert property (take && hit && cmd_id == 16'h0001 |->
        ##3 rsp_valid_r && rsp_id_r == 16'h8001 && rsp_payload_r == 32'h00000000)
        else $error("ping reply wrong");
    mode_store_a: assert property (take && cmd_id == 16'h0003 |->
        ##2 {28'h0000000, acq_mode_r} == ($past(cmd_payload, 2) & 32'h0000000F))
        else $error("mode not stored from low nibble");
    mode_read_a: assert property (take && hit && cmd_id == 16'h0004 |->
        ##3 rsp_valid_r && rsp_payload_r == {28'h0000000, acq_mode_r})
        else $error("mode read payload wrong");
    unknown_err_a: assert property (take && hit && !cmd_id[12] && (base_id == 16'h0000 ||
        base_id > 16'h000A) |-> ##3 rsp_valid_r && rsp_id_r == 16'h7F04)
        else $error("unknown id not refused");
    async_fast_a: assert property (take && hit && cmd_id[12] |->
        ##2 rsp_valid_r && rsp_id_r == ($past(cmd_id, 2) | 16'h8000))
        else $error("async reply not prompt");
    bcast_quiet_a: assert property (take && cmd_dest[15] && !hit |-> ##1 (!rsp_valid_r) [*8])
        else $error("broadcast reply from wrong node");
    reset_act_a: assert property (take && cmd_id == 16'h0007 && cmd_payload[3:0] == 4'h0 |->
        ##2 acq_mode_r == 4'h0 && acq_settings_r == 32'h00000000)
        else $error("reset action left mode or settings");
endmodule // acqh_cmd_handler_monitor

bind acqh_cmd_handler acqh_cmd_handler_monitor u_mon (.clk(clk), .resetn(resetn),
    .node_addr(node_addr), .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_dest(cmd_dest),
    .cmd_payload(cmd_payload), .cmd_busy_r(cmd_busy_r), .rsp_valid_r(rsp_valid_r),
    .rsp_id_r(rsp_id_r), .rsp_src_r(rsp_src_r), .rsp_payload_r(rsp_payload_r),
    .acq_mode_r(acq_mode_r), .acq_settings_r(acq_settings_r), .trig_mask_r(trig_mask_r),
    .chan_trig(chan_trig), .chan_trig_ok_r(chan_trig_ok_r));

// [dv/acqh_flash_model.sv]
`timescale 1ns/10ps
// Flash holding the child bitstream
module acqh_flash_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic flash_rd_r,
    output logic [31:0] flash_data
);
    logic [7:0] idx_r; // Word counter, makes each word distinct
    // Word stands while the read strobe is high; between reads the bus shows its inverse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx_r <= 8'h00;
        end else if (flash_rd_r) begin
            idx_r <= idx_r + 8'h01;
        end
    end
    assign flash_data = flash_rd_r ? {24'hC0FFEE, idx_r} : ~{24'hC0FFEE, idx_r};
endmodule // acqh_flash_model

// [dv/tb_acq_mode_command_handler.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
// Parent-side bench: sends commands, judges replies and register outputs
module tb_acq_mode_command_handler;
    localparam logic [15:0] node_me = 16'h0002; // Address given to the node
    logic clk, resetn, cmd_valid, cmd_busy_r, rsp_valid_r, acq_running_r, scope_en_r;
    logic singles_en_r, flash_rd_r, child_we_r;
    logic [15:0] node_addr, cmd_id, cmd_dest, rsp_id_r, rsp_src_r;
    logic [31:0] cmd_payload, rsp_payload_r, acq_settings_r, trig_mask_r, chan_trig;
    logic [31:0] chan_trig_ok_r, flash_data, child_data_r;
    logic [3:0] acq_mode_r, acq_action_r, scope_pretrig_r, scope_window_r, singles_ticks_r;
    logic [8:0] scope_total_r;
    int err_total, checks_done, we_cnt;
    logic [3:0] mv [4] = '{4'h0, 4'h1, 4'h2, 4'h5}; // Defined modes plus one undefined
    acqh_cmd_handler u_dut (.clk(clk), .resetn(resetn), .node_addr(node_addr),
        .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_dest(cmd_dest), .cmd_payload(cmd_payload),
        .cmd_busy_r(cmd_busy_r), .rsp_valid_r(rsp_valid_r), .rsp_id_r(rsp_id_r),
        .rsp_src_r(rsp_src_r), .rsp_payload_r(rsp_payload_r), .acq_mode_r(acq_mode_r),
        .acq_settings_r(acq_settings_r), .acq_action_r(acq_action_r), .trig_mask_r(trig_mask_r),
        .acq_running_r(acq_running_r), .scope_en_r(scope_en_r), .singles_en_r(singles_en_r),
        .scope_total_r(scope_total_r), .scope_pretrig_r(scope_pretrig_r),
        .scope_window_r(scope_window_r), .singles_ticks_r(singles_ticks_r),
        .chan_trig(chan_trig), .chan_trig_ok_r(chan_trig_ok_r), .flash_rd_r(flash_rd_r),
        .flash_data(flash_data), .child_data_r(child_data_r), .child_we_r(child_we_r));
    acqh_flash_model u_flash (.clk(clk), .resetn(resetn), .flash_rd_r(flash_rd_r),
        .flash_data(flash_data));
    // Clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Counts and checks the words written into the children
    always @(negedge clk) begin
        if (child_we_r === 1'b1) begin
            `CHK("child word", {24'hC0FFEE, we_cnt[7:0]}, child_data_r)
            we_cnt++;
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Bounded wait until the handler is ready for the next command
    task automatic idle();
        for (int n = 0; n < 300 && cmd_busy_r !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        if (cmd_busy_r !== 1'b0) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // One command; want says whether a reply must come, else none may
    task automatic cmd(input logic [15:0] id, input logic [15:0] dst, input logic [31:0] pay,
        input logic [15:0] eid, input logic [31:0] epay, input bit want);
        bit seen;
        @(posedge clk);
        #10 cmd_id = id;
        cmd_dest = dst;
        cmd_payload = pay;
        cmd_valid = 1'b1;
        @(posedge clk);
        #10 cmd_valid = 1'b0;
        seen = 1'b0;
        for (int n = 0; n < 40 && !seen; n++) begin
            @(posedge clk);
            #1;
            if (rsp_valid_r === 1'b1) begin
                seen = 1'b1;
                if (want) begin
                    `CHK("reply id", eid, rsp_id_r)
                    `CHK("reply src", node_me, rsp_src_r)
                    `CHK("reply payload", epay, rsp_payload_r)
                end
            end
        end
        `CHK("reply present", want, seen)
        if (want && !seen) report_and_stop();
        // Async replies leave the node busy; the scenario decides when to wait
        if (!eid[12]) idle();
    endtask
    task automatic t_power_up();
        idle();
        `CHK("power-up words", 16, we_cnt)
        `CHK("settings reset", 32'h00000000, acq_settings_r)
        cmd(16'h000A, node_me, 32'hDEADFEED, 16'h800A, 32'h00000000, 1);
        cmd(16'h0001, node_me, 32'hDEADFEED, 16'h8001, 32'h00000000, 1);
    endtask
    task automatic t_modes();
        foreach (mv[i]) begin
            cmd(16'h0003, node_me, {28'hFFFFFFF, mv[i]}, 16'h8003, {28'hFFFFFFF, mv[i]}, 1);
            cmd(16'h0004, node_me, 32'hDEADFEED, 16'h8004, {28'h0000000, mv[i]}, 1);
            `CHK("mode reg", mv[i], acq_mode_r)
        end
    endtask
    task automatic t_scope();
        // Host order: mode, then settings with total above pretrig plus window, then run
        cmd(16'h0003, node_me, 32'h00000001, 16'h8003, 32'h00000001, 1);
        cmd(16'h0005, node_me, 32'h02000101, 16'h8005, 32'h02000101, 1);
        `CHK("scope total", 9'h010, scope_total_r)
        `CHK("scope pretrig", 4'h0, scope_pretrig_r)
        `CHK("scope window", 4'h2, scope_window_r)
        cmd(16'h0006, node_me, 32'hDEADFEED, 16'h8006, 32'h02000101, 1);
        cmd(16'h0007, node_me, 32'h00000002, 16'h8007, 32'h00000002, 1);
        `CHK("scope run", 2'b11, {acq_running_r, scope_en_r})
        cmd(16'h0008, node_me, 32'hDEADFEED, 16'h8008, 32'h00000002, 1);
        cmd(16'h0007, node_me, 32'h00000001, 16'h8007, 32'h00000001, 1);
        `CHK("stopped", 1'b0, acq_running_r)
    endtask
    task automatic t_singles();
        cmd(16'h0003, node_me, 32'h00000002, 16'h8003, 32'h00000002, 1);
        cmd(16'h0005, node_me, 32'h00000005, 16'h8005, 32'h00000005, 1);
        cmd(16'h0007, node_me, 32'h00000002, 16'h8007, 32'h00000002, 1);
        `CHK("singles ticks", 4'h5, singles_ticks_r)
        `CHK("singles run", 1'b1, singles_en_r)
        cmd(16'h0007, node_me, 32'h00000003, 16'h8007, 32'h00000003, 1);
        `CHK("odd action kept", 2'b11, {acq_running_r, acq_action_r == 4'h3})
        cmd(16'h0007, node_me, 32'h00000000, 16'h8007, 32'h00000000, 1);
        `CHK("reset mode", 36'h0, {acq_mode_r, acq_settings_r})
    endtask
    task automatic t_mask();
        cmd(16'h0009, node_me, 32'h00000121, 16'h8009, 32'h00000121, 1);
        cmd(16'h000A, node_me, 32'hDEADFEED, 16'h800A, 32'h00000121, 1);
        #10 chan_trig = 32'hFFFFFFFF;
        repeat (2) @(posedge clk);
        #1;
        `CHK("masked trig", 32'h00000121, chan_trig_ok_r)
    endtask
    task automatic t_route();
        cmd(16'h0003, 16'h8005, 32'h00000001, 16'h0000, 32'h00000000, 0);
        `CHK("bcast mode", 4'h1, acq_mode_r)
        cmd(16'h0001, 16'h8002, 32'h00000000, 16'h8001, 32'h00000000, 1);
        cmd(16'h000B, node_me, 32'h00000000, 16'h7F04, 32'h00000000, 1);
        cmd(16'h1001, node_me, 32'h00000000, 16'h9001, 32'h00000000, 1);
        idle();
    endtask
    task automatic t_config();
        cmd(16'h0002, node_me, 32'h00000000, 16'h8002, 32'h00000000, 1);
        `CHK("config words", 32, we_cnt)
        cmd(16'h1002, node_me, 32'h00000000, 16'h9002, 32'h00000000, 1);
        `CHK("busy in async", 1'b1, cmd_busy_r)
        cmd(16'h0001, node_me, 32'h00000000, 16'h0000, 32'h00000000, 0);
        `CHK("async words", 48, we_cnt)
    endtask
    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_id = 16'h0000;
        cmd_dest = 16'h0000;
        cmd_payload = 32'h00000000;
        chan_trig = 32'h00000000;
        node_addr = node_me;
        repeat (5) @(posedge clk);
        #10 resetn = 1'b1;
        t_power_up();
        t_modes();
        t_scope();
        t_singles();
        t_mask();
        t_route();
        t_config();
        report_and_stop();
    end
endmodule // tb_acq_mode_command_handler
